// >>> hw/pie_regs.svh
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH

// Global register byte offsets.
`define PIE_OFS_IRQ_STAT    12'h000
`define PIE_OFS_IRQ_EN      12'h004
`define PIE_OFS_IRQ_CLR     12'h008
`define PIE_OFS_LINE        12'h00C

// Per-port register block: base, stride and offsets inside the block.
`define PIE_OFS_PORT_BASE   12'h010
`define PIE_PORT_STRIDE_SH  4
`define PIE_POFS_LEVEL      2'h0
`define PIE_POFS_RISE_EN    2'h1
`define PIE_POFS_FALL_EN    2'h2
`define PIE_POFS_FLAGS      2'h3

// Field positions inside the event, flag and line words.
`define PIE_EVT_GRP0_BIT    6
`define PIE_EVT_GRP1_BIT    7
`define PIE_FLAG_RISE_LSB   0
`define PIE_FLAG_FALL_LSB   8
`define PIE_LINE_LVL_BIT    0

// Reset values.
`define PIE_RST_EN          8'h00
`define PIE_RST_IRQ_EN      8'h00

// Timing.
`define PIE_CLK_MHZ         100
`define PIE_INT_LAT_MAX_US  50
`define PIE_INT_LAT_MAX_CYC (`PIE_INT_LAT_MAX_US * `PIE_CLK_MHZ)
`define PIE_PRIME_CYC       3

`endif

// >>> hw/pie_pkg.sv
package pie_pkg;

    typedef logic [5:0]  pie_pins_type;
    typedef logic [7:0]  pie_evt_type;
    typedef logic [15:0] pie_flag_type;

endpackage

// >>> hw/pie_sync_edge.sv
`timescale 1ns/100ps
`include "pie_regs.svh"

module pie_sync_edge
    import pie_pkg::*;
#(
    parameter int W = 6
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0]                meta_ff;
    logic [W-1:0]                sync_ff;
    logic [W-1:0]                prev_ff;
    logic [`PIE_PRIME_CYC-1:0]   prime_ff;
    wire                         primed;

    // The first stage feeds only the second one.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff  <= '0;
            sync_ff  <= '0;
            prev_ff  <= '0;
            prime_ff <= '0;
        end else begin
            meta_ff  <= din;
            sync_ff  <= meta_ff;
            prev_ff  <= sync_ff;
            prime_ff <= {prime_ff[`PIE_PRIME_CYC-2:0], 1'b1};
        end
    end

    // Edges are held off until the delay line carries real samples, so a
    // pin that is already high at reset release does not look like a rise.
    assign primed = prime_ff[`PIE_PRIME_CYC-1];
    assign lvl    = sync_ff;
    assign rise   = primed ? (sync_ff & ~prev_ff) : '0; // R11
    assign fall   = primed ? (~sync_ff & prev_ff) : '0; // R11

endmodule

// >>> hw/pie_flag_cell.sv
`timescale 1ns/100ps
`include "pie_regs.svh"

module pie_flag_cell
    import pie_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire pie_pins_type rise,
    input  wire pie_pins_type fall,
    input  wire pie_evt_type  rise_en,
    input  wire pie_evt_type  fall_en,
    input  wire pie_flag_type clr_mask,
    output pie_flag_type      flags,
    output logic              new_evt
);

    pie_evt_type  rise_evt;
    pie_evt_type  fall_evt;
    pie_flag_type set_vec;
    pie_flag_type flags_ff;

    // Six single-pin events plus one combined event per group of three.
    assign rise_evt = {|rise[5:3], |rise[2:0], rise} & rise_en; // R04 R08
    assign fall_evt = {|fall[5:3], |fall[2:0], fall} & fall_en; // R04 R08
    assign set_vec  = {fall_evt, rise_evt};                      // R05

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= (flags_ff & ~clr_mask) | set_vec; // R12
        end
    end

    assign flags   = flags_ff;
    assign new_evt = |set_vec; // R03

endmodule

// >>> hw/pie_top.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`include "pie_regs.svh"

// Behaviour
// R01: Each port has six status inputs, two groups of three, watched by the block.
// R02: The synchronised level of every status input of each port is readable over the bus.
// R03: When enabled, a change on one or more watched inputs raises the host interrupt.
// R04: Each event can be armed for falling edges, rising edges, or both.
// R05: One flag register per port records which inputs and which directions fired.
// R06: The host interrupt pin is pulled low while an enabled interrupt event is pending.
// R07: The interrupt pin only pulls low and is otherwise released, so devices can share it.
// R08: Each edge type can be armed for a single input or for any input of a group of three.
// R09: The interrupt pin asserts within 50 us of a watched input changing.
// R10: The host reads the per-port summary, then the flags, until the shared line releases.
// R11: Inputs are synchronised before edge detection so each transition flags exactly once.
// R12: Flags and the interrupt stay set until the host clears them; reading the flags clears them.

module pie_top
    import pie_pkg::*;
#(
    parameter int NUM_PORTS       = 2,
    parameter int ADDR_W          = 12,
    parameter int INT_LAT_MAX_CYC = `PIE_INT_LAT_MAX_CYC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [NUM_PORTS-1:0] grp0_input_a,
    input  wire logic [NUM_PORTS-1:0] grp0_input_b,
    input  wire logic [NUM_PORTS-1:0] grp0_input_c,
    input  wire logic [NUM_PORTS-1:0] grp1_input_a,
    input  wire logic [NUM_PORTS-1:0] grp1_input_b,
    input  wire logic [NUM_PORTS-1:0] grp1_input_c,
    input  wire logic                 host_int_n_in,
    output logic                      host_int_n_out,
    output logic                      host_int_n_oe_n,
    output logic                      irq
);

    localparam int PIDX_W = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
    localparam int PREL_W = ADDR_W - `PIE_PORT_STRIDE_SH;

    ////////////////////////////////////////////////////////////////////////////
    // Bus phase decode.

    logic [31:0]             prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic [31:0]             nxt_prdata;
    logic                    nxt_pslverr;

    wire                     acc_setup;
    wire                     acc_done;
    wire                     wr_done;
    wire                     rd_done;
    wire  [31:0]             wmask;

    // No wait states: the answer is prepared in the setup cycle and the
    // access phase completes on its first edge.
    assign acc_setup = psel & ~penable;
    assign acc_done  = psel & penable & pready_ff;
    assign wr_done   = acc_done & pwrite;
    assign rd_done   = acc_done & ~pwrite;
    assign wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    wire                     aligned;
    wire                     hit_stat;
    wire                     hit_en;
    wire                     hit_clr;
    wire                     hit_line;
    wire  [ADDR_W-1:0]       port_rel;
    wire  [PREL_W-1:0]       port_idx_w;
    wire  [PIDX_W-1:0]       port_idx;
    wire  [1:0]              port_reg;
    wire                     hit_port;
    wire                     hit_any;

    assign aligned    = (paddr[1:0] == 2'h0);
    assign hit_stat   = (paddr == `PIE_OFS_IRQ_STAT);
    assign hit_en     = (paddr == `PIE_OFS_IRQ_EN);
    assign hit_clr    = (paddr == `PIE_OFS_IRQ_CLR);
    assign hit_line   = (paddr == `PIE_OFS_LINE);
    assign port_rel   = paddr - ADDR_W'(`PIE_OFS_PORT_BASE);
    assign port_idx_w = port_rel[ADDR_W-1:`PIE_PORT_STRIDE_SH];
    assign port_idx   = port_idx_w[PIDX_W-1:0];
    assign port_reg   = port_rel[3:2];
    assign hit_port   = aligned && (paddr >= ADDR_W'(`PIE_OFS_PORT_BASE))
                        && (port_idx_w < PREL_W'(NUM_PORTS));
    assign hit_any    = hit_stat | hit_en | hit_clr | hit_line | hit_port;

    ////////////////////////////////////////////////////////////////////////////
    // Per-port input path, configuration and flags.

    pie_pins_type            lvl_w     [NUM_PORTS];
    pie_evt_type             rise_en_ff[NUM_PORTS];
    pie_evt_type             fall_en_ff[NUM_PORTS];
    pie_flag_type            flags_w   [NUM_PORTS];
    logic [NUM_PORTS-1:0]    evt_vec;

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            pie_pins_type pins;
            pie_pins_type rise_w;
            pie_pins_type fall_w;
            pie_flag_type clr_mask;
            wire          sel_p;
            wire          wr_rise;
            wire          wr_fall;

            // Group 0 in bits 2:0, group 1 in bits 5:3.
            assign pins = {grp1_input_c[p], grp1_input_b[p], grp1_input_a[p],
                           grp0_input_c[p], grp0_input_b[p], grp0_input_a[p]}; // R01

            pie_sync_edge #(
                .W       (6)
            ) u_sync (
                .pclk    (pclk),
                .presetn (presetn),
                .din     (pins),
                .lvl     (lvl_w[p]),
                .rise    (rise_w),
                .fall    (fall_w)
            );

            assign sel_p   = hit_port && (port_idx_w == PREL_W'(p));
            assign wr_rise = wr_done && sel_p && (port_reg == `PIE_POFS_RISE_EN) && pstrb[0];
            assign wr_fall = wr_done && sel_p && (port_reg == `PIE_POFS_FALL_EN) && pstrb[0];

            // Only the bits that went out with the read are cleared, so a flag
            // that rises between the capture and the end of the read survives.
            assign clr_mask = (rd_done && sel_p && (port_reg == `PIE_POFS_FLAGS))
                              ? prdata_ff[15:0] : '0; // R12

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rise_en_ff[p] <= `PIE_RST_EN;
                    fall_en_ff[p] <= `PIE_RST_EN;
                end else begin
                    if (wr_rise) begin
                        rise_en_ff[p] <= pwdata[7:0]; // R04 R08
                    end
                    if (wr_fall) begin
                        fall_en_ff[p] <= pwdata[7:0]; // R04 R08
                    end
                end
            end

            pie_flag_cell u_flags (
                .pclk     (pclk),
                .presetn  (presetn),
                .rise     (rise_w),
                .fall     (fall_w),
                .rise_en  (rise_en_ff[p]),
                .fall_en  (fall_en_ff[p]),
                .clr_mask (clr_mask),
                .flags    (flags_w[p]),
                .new_evt  (evt_vec[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Aggregated per-port status, enable and interrupt pin.

    logic [NUM_PORTS-1:0]    stat_ff;
    logic [NUM_PORTS-1:0]    irq_en_ff;
    logic                    irq_ff;
    logic                    int_oe_n_ff;
    logic                    int_out_ff;
    logic                    line_ff;
    wire  [NUM_PORTS-1:0]    stat_clr;
    wire  [NUM_PORTS-1:0]    en_wmask;
    wire                     nxt_irq;

    assign stat_clr = (wr_done && hit_clr) ? (pwdata[NUM_PORTS-1:0] & wmask[NUM_PORTS-1:0])
                                           : '0;
    assign en_wmask = (wr_done && hit_en) ? wmask[NUM_PORTS-1:0] : '0;
    assign nxt_irq  = |(stat_ff & irq_en_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_ff     <= '0;
            irq_en_ff   <= NUM_PORTS'(`PIE_RST_IRQ_EN);
            irq_ff      <= 1'b0;
            int_oe_n_ff <= 1'b1;
            int_out_ff  <= 1'b0;
            line_ff     <= 1'b1;
        end else begin
            // A new event in the clearing cycle keeps its bit set.
            stat_ff     <= (stat_ff & ~stat_clr) | evt_vec; // R03 R12
            irq_en_ff   <= (irq_en_ff & ~en_wmask) | (pwdata[NUM_PORTS-1:0] & en_wmask);
            irq_ff      <= nxt_irq;  // R06 R09
            int_oe_n_ff <= ~nxt_irq; // R06 R07
            int_out_ff  <= 1'b0;     // R07
            line_ff     <= host_int_n_in; // R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and response.

    wire  [31:0]             rd_port;
    wire  [31:0]             rd_glob;

    assign rd_port = (port_reg == `PIE_POFS_LEVEL)   ? {26'h0, lvl_w[port_idx]} :      // R02
                     (port_reg == `PIE_POFS_RISE_EN) ? {24'h0, rise_en_ff[port_idx]} :
                     (port_reg == `PIE_POFS_FALL_EN) ? {24'h0, fall_en_ff[port_idx]} :
                                                       {16'h0, flags_w[port_idx]};     // R05
    assign rd_glob = hit_stat ? 32'(stat_ff) :                                         // R10
                     hit_en   ? 32'(irq_en_ff) :
                     hit_line ? 32'(line_ff) :
                                32'h0000_0000;

    always_comb begin
        nxt_prdata  = prdata_ff;
        nxt_pslverr = pslverr_ff;
        if (acc_setup) begin
            nxt_pslverr = ~hit_any;
            if (pwrite || !hit_any) begin
                nxt_prdata = 32'h0000_0000;
            end else if (hit_port) begin
                nxt_prdata = rd_port;
            end else begin
                nxt_prdata = rd_glob;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= acc_setup;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign irq             = irq_ff;
    assign host_int_n_oe_n = int_oe_n_ff;
    assign host_int_n_out  = int_out_ff;

endmodule

// >>> tb/pie_checker.sv
`timescale 1ns/100ps
`include "pie_regs.svh"

module pie_checker #(
    parameter int NUM_PORTS = 2,
    parameter int ADDR_W    = 12
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [NUM_PORTS-1:0] grp0_input_a,
    input wire logic [NUM_PORTS-1:0] grp0_input_b,
    input wire logic [NUM_PORTS-1:0] grp0_input_c,
    input wire logic [NUM_PORTS-1:0] grp1_input_a,
    input wire logic [NUM_PORTS-1:0] grp1_input_b,
    input wire logic [NUM_PORTS-1:0] grp1_input_c,
    input wire logic                 host_int_n_out,
    input wire logic                 host_int_n_oe_n,
    input wire logic                 irq
);
    wire [6*NUM_PORTS-1:0] pins = {grp1_input_c, grp1_input_b, grp1_input_a,
                                   grp0_input_c, grp0_input_b, grp0_input_a};
    wire ctl_wr = psel && penable && pready && pwrite &&
                  (paddr == `PIE_OFS_IRQ_EN || paddr == `PIE_OFS_IRQ_CLR);
    logic [6*NUM_PORTS-1:0] pins_ff;
    logic [3:0]             since_ff;

    // Age of the last cause of an interrupt; it saturates so a long quiet spell never wraps.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_ff  <= '0;
            since_ff <= 4'hF;
        end else begin
            pins_ff  <= pins;
            since_ff <= (pins != pins_ff || ctl_wr) ? 4'h0 : since_ff + {3'h0, since_ff != 4'hF};
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ans_wait_a: assert property (psel && !penable |=> pready) else $error("setup not answered");
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    wr_data_zero_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write returned data");
    bad_addr_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("unaligned not refused");
    drive_low_a: assert property (host_int_n_out == 1'b0) else $error("interrupt pin driven high");
    oe_follow_a: assert property (host_int_n_oe_n == !irq) else $error("pin enable not following irq");
    irq_hold_a: assert property ($fell(irq) |-> $past(ctl_wr) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
        else $error("irq dropped without host clear");
    irq_cause_a: assert property ($rose(irq) |-> since_ff <= 4'hC) else $error("irq without recent cause");

    cover property ($rose(irq));
    cover property ($fell(irq));
    cover property (pready && pslverr);
endmodule

bind pie_top pie_checker #(.NUM_PORTS(NUM_PORTS), .ADDR_W(ADDR_W)) u_chk (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .prdata, .pready, .pslverr, .grp0_input_a, .grp0_input_b, .grp0_input_c,
    .grp1_input_a, .grp1_input_b, .grp1_input_c, .host_int_n_out, .host_int_n_oe_n, .irq);

// >>> tb/pie_module_model.sv
`timescale 1ns/100ps

module pie_module_model #(
    parameter int NUM_PORTS = 2
) (
    input wire logic [0:0]             pclk,
    input wire logic [6*NUM_PORTS-1:0] lvl_cmd,
    output logic     [NUM_PORTS-1:0]   grp0_input_a,
    output logic     [NUM_PORTS-1:0]   grp0_input_b,
    output logic     [NUM_PORTS-1:0]   grp0_input_c,
    output logic     [NUM_PORTS-1:0]   grp1_input_a,
    output logic     [NUM_PORTS-1:0]   grp1_input_b,
    output logic     [NUM_PORTS-1:0]   grp1_input_c
);
    // Module outputs are push-pull, so they always show a level; they move only after a clock edge.
    logic [6*NUM_PORTS-1:0] pins_ff = '0;

    always @(posedge pclk) begin
        pins_ff <= lvl_cmd;
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        assign grp0_input_a[p] = pins_ff[p*6];
        assign grp0_input_b[p] = pins_ff[p*6+1];
        assign grp0_input_c[p] = pins_ff[p*6+2];
        assign grp1_input_a[p] = pins_ff[p*6+3];
        assign grp1_input_b[p] = pins_ff[p*6+4];
        assign grp1_input_c[p] = pins_ff[p*6+5];
    end
endmodule

// >>> tb/test_port_input_edge_interrupt.sv
`timescale 1ns/100ps
`include "pie_regs.svh"

module test_port_input_edge_interrupt;
    logic        pclk, presetn, psel, penable, pwrite, other_low, err;
    logic [11:0] paddr, lvl_cmd;
    logic [31:0] pwdata, prdata, rd, lfsr, ien;
    logic [3:0]  pstrb;
    logic [1:0]  grp0_input_a, grp0_input_b, grp0_input_c, grp1_input_a, grp1_input_b, grp1_input_c;
    logic        pready, pslverr, host_int_n_out, host_int_n_oe_n, irq;
    int          mismatches, tests_run, cyc, n, pin;
    // The shared line is pulled up unless this device or a neighbour pulls it low.
    wire         int_wire = (host_int_n_oe_n === 1'b0 || other_low) ? 1'b0 : 1'b1;

    pie_module_model #(.NUM_PORTS(2)) u_mod (.pclk, .lvl_cmd, .grp0_input_a, .grp0_input_b, .grp0_input_c,
        .grp1_input_a, .grp1_input_b, .grp1_input_c);
    pie_top #(.NUM_PORTS(2), .ADDR_W(12)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .grp0_input_a, .grp0_input_b, .grp0_input_c, .grp1_input_a,
        .grp1_input_b, .grp1_input_c, .host_int_n_in(int_wire), .host_int_n_out, .host_int_n_oe_n, .irq);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [11:0] padr(input int p, input int o);
        return `PIE_OFS_PORT_BASE + 12'(p << `PIE_PORT_STRIDE_SH) + 12'(o << 2);
    endfunction

    function automatic logic [31:0] exp_flags(input int b, input int m);
        return (m != 1 ? 32'h1 << b : 32'h0) | (m != 0 ? 32'h100 << b : 32'h0);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends this wait; the slave answers in one access cycle.
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1);
        check("pready wait", w, 1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata, other_low, lvl_cmd, presetn} = '0;
        pstrb = 4'hF;
        lfsr = 32'h1400;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `PIE_OFS_IRQ_EN, 0);
        check("irq_en reset", rd, 0);
        check("oe_n reset", host_int_n_oe_n, 1'b1);
        apb(0, 12'hFF0, 0);
        check("unmapped err", err, 1'b1);
        apb(1, 12'h016, 32'hFFFF_FFFF);
        check("unaligned err", err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt_rand(lfsr);
            apb(0, padr(i >> 1, 1 + (i & 1)), 0);
            check("enable reset", rd, 0);
            apb(1, padr(i >> 1, 1 + (i & 1)), lfsr);
            apb(0, padr(i >> 1, 1 + (i & 1)), 0);
            check("enable rw", rd, {24'h0, lfsr[7:0]});
            apb(1, padr(i >> 1, 1 + (i & 1)), 0);
        end
        apb(1, padr(0, 0), 32'h3F);
        apb(0, padr(0, 0), 0);
        check("level ro", rd, 0);
        apb(0, `PIE_OFS_IRQ_CLR, 0);
        check("clr reads zero", rd, 0);
        // A write without the low byte strobe must leave the enable untouched.
        pstrb <= 4'hE;
        apb(1, padr(1, 1), 32'hFF);
        pstrb <= 4'hF;
        apb(0, padr(1, 1), 0);
        check("strobe gate", rd, 0);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            lfsr = nxt_rand(lfsr);
            lvl_cmd <= lfsr[11:0];
            repeat (4) @(posedge pclk);
            apb(0, padr(0, 0), 0);
            check("level p0", rd, {26'h0, lvl_cmd[5:0]});
            apb(0, padr(1, 0), 0);
            check("level p1", rd, {26'h0, lvl_cmd[11:6]});
        end
        lvl_cmd <= '0;
        other_low <= 1'b1;
        apb(0, `PIE_OFS_LINE, 0);
        check("line shared", rd, 0);
        other_low <= 1'b0;
        $display("test levels done");
        for (int p = 0; p < 2; p++) for (int m = 0; m < 3; m++) for (int b = 0; b < 8; b++) begin
            lfsr = nxt_rand(lfsr);
            pin = b < 6 ? b : (b - 6) * 3 + int'(lfsr[7:0] % 3);
            apb(1, padr(p, 1), m != 1 ? 32'h1 << b : 0);
            apb(1, padr(p, 2), m != 0 ? 32'h1 << b : 0);
            ien = (m == 0 && b == 0) ? 0 : 32'h1 << p;
            apb(1, `PIE_OFS_IRQ_EN, ien);
            lvl_cmd[p*6+pin] <= 1'b1;
            repeat (8) @(posedge pclk);
            lvl_cmd[p*6+pin] <= 1'b0;
            repeat (8) @(posedge pclk);
            for (n = 0; n < 5000 && irq !== (ien != 0); n++) @(posedge pclk);
            check("irq", irq, ien != 0);
            check("oe_n", host_int_n_oe_n, ien == 0);
            check("int out", host_int_n_out, 1'b0);
            apb(0, `PIE_OFS_LINE, 0);
            check("line", rd, {31'h0, ien == 0});
            repeat (20) @(posedge pclk);
            apb(0, padr(p, 3), 0);
            check("flags", rd, exp_flags(b, m));
            apb(0, padr(p, 3), 0);
            check("flags cleared", rd, 0);
            check("irq held", irq, ien != 0);
            apb(0, `PIE_OFS_IRQ_STAT, 0);
            check("stat", rd, 32'h1 << p);
            apb(1, `PIE_OFS_IRQ_CLR, 32'h1 << p);
            repeat (3) @(posedge pclk);
            check("irq cleared", irq, 1'b0);
        end
        $display("test edges done");
        results();
    end
endmodule
